// File: hw/wutcd_defs.svh
// register indices, field positions, reset values and divider counts
`ifndef WUTCD_DEFS_SVH
`define WUTCD_DEFS_SVH

// register indices; byte address is four times the index
`define WUTCD_IDX_COMP_RELOAD_HI 8'h1f
`define WUTCD_IDX_COMP_RELOAD_LO 8'h20
`define WUTCD_IDX_COMP_COUNT_HI  8'h21
`define WUTCD_IDX_COMP_COUNT_LO  8'h22
`define WUTCD_IDX_WAKE_CTRL      8'h23
`define WUTCD_IDX_WAKE_RELOAD_HI 8'h24
`define WUTCD_IDX_WAKE_RELOAD_LO 8'h25
`define WUTCD_IDX_WAKE_COUNT_HI  8'h26
`define WUTCD_IDX_WAKE_COUNT_LO  8'h27
`define WUTCD_IDX_STATUS         8'h30

// wake timer control fields
`define WUTCD_CTRL_ACTIVE        7
`define WUTCD_CTRL_GATE          6
`define WUTCD_CTRL_TRIM          5
`define WUTCD_CTRL_CARD_DETECT   4
`define WUTCD_CTRL_RELOAD        3
`define WUTCD_CTRL_AUTO_WAKE     2
`define WUTCD_CTRL_CLKSEL_HI     1
`define WUTCD_CTRL_CLKSEL_LO     0

// status fields
`define WUTCD_STAT_IRQ_FLAG      0
`define WUTCD_STAT_CARD_FLAG     1
`define WUTCD_STAT_DETECT_BUSY   2
`define WUTCD_STAT_CARD_SEEN     3

// reset values
`define WUTCD_RST_BYTE           8'h00
`define WUTCD_RST_WORD           16'h0000
`define WUTCD_RST_SEL            2'h0

// count clock selection codes and last prescaler count of each divided code
`define WUTCD_SEL_DIRECT         2'h0
`define WUTCD_SEL_DIV8           2'h1
`define WUTCD_SEL_DIV16          2'h2
`define WUTCD_SEL_DIV32          2'h3
`define WUTCD_DIV8_LAST          5'h07
`define WUTCD_DIV16_LAST         5'h0f
`define WUTCD_DIV32_LAST         5'h1f

`endif

// File: hw/wutcd_pkg.sv
// types shared by the wake-up timer and its count clock prescaler
package wutcd_pkg;

  typedef enum logic [1:0] {
    WUTCD_DET_IDLE  = 2'b00,
    WUTCD_DET_FIELD = 2'b01,
    WUTCD_DET_DONE  = 2'b10
  } wutcd_det_t;

  typedef struct packed {
    logic [4:0] count;
    logic       tick;
  } wutcd_pre_state_t;

  typedef struct packed {
    // bus answer
    logic        ack;
    logic [31:0] rdata;
    // companion timer
    logic [7:0]  comp_reload_hi;
    logic [7:0]  comp_reload_lo;
    logic [15:0] comp_count;
    // wake timer control and count
    logic        active;
    logic        trim;
    logic        card_detect;
    logic        reload;
    logic        auto_wake;
    logic [1:0]  clk_sel;
    logic [7:0]  wake_reload_hi;
    logic [7:0]  wake_reload_lo;
    logic [15:0] wake_count;
    // flags and detection sequence
    logic        irq_flag;
    logic        card_flag;
    logic        card_seen;
    wutcd_det_t  det;
    // outputs
    logic        irq;
    logic        wake_up;
    logic        trim_start;
    logic        power_down;
    logic        stay_active;
    logic        detect_start;
    logic        rf_field;
  } wutcd_state_t;

endpackage

// File: hw/wutcd_prescale.sv
// count clock prescaler: passes or divides the oscillator tick
`timescale 1ns/1ns
`default_nettype none
`include "wutcd_defs.svh"

module wutcd_prescale (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_b_in,
  // control
  input  wire logic       clear_in,
  input  wire logic [1:0] sel_in,
  input  wire logic       lfo_tick_in,
  // divided tick
  output logic            tick_out
);

  wutcd_pkg::wutcd_pre_state_t s_ff;
  wutcd_pkg::wutcd_pre_state_t nxt_s;

  function automatic logic [4:0] last_count(input logic [1:0] sel);
    if (sel == `WUTCD_SEL_DIV8) begin
      last_count = `WUTCD_DIV8_LAST;
    end else if (sel == `WUTCD_SEL_DIV16) begin
      last_count = `WUTCD_DIV16_LAST;
    end else begin
      last_count = `WUTCD_DIV32_LAST;
    end
  endfunction

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    // restart the phase so the first period is a whole one
    if (clear_in) begin
      nxt_s.count = 5'h00;
    end else if (lfo_tick_in) begin
      if (sel_in == `WUTCD_SEL_DIRECT) begin
        nxt_s.tick = 1'b1;
        nxt_s.count = 5'h00;
      end else if (s_ff.count >= last_count(sel_in)) begin
        nxt_s.tick = 1'b1;
        nxt_s.count = 5'h00;
      end else begin
        nxt_s.count = s_ff.count + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tick_out = s_ff.tick;

endmodule
`default_nettype wire

// File: hw/wutcd_top.sv
// wake-up timer with card detect sequencing and companion field timer
`timescale 1ns/1ns
`default_nettype none
`include "wutcd_defs.svh"

module wutcd_top (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  // wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [11:0] wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  // count clock sources
  input  wire logic        lfo_tick_in,
  input  wire logic        comp_tick_in,
  // analogue side of detection and trimming
  input  wire logic        card_present_in,
  input  wire logic        trim_done_in,
  // power and event outputs
  output logic             irq_out,
  output logic             wake_up_out,
  output logic             trim_start_out,
  output logic             power_down_out,
  output logic             stay_active_out,
  output logic             detect_start_out,
  output logic             rf_field_out
);

  wutcd_pkg::wutcd_state_t s_ff;
  wutcd_pkg::wutcd_state_t nxt_s;

  logic       wb_req;
  logic       wb_adr_ok;
  logic [7:0] wb_idx;
  logic       wb_wr;
  logic       ctrl_wr;
  logic       wake_start;
  logic       wake_stop;
  logic       presc_tick;
  logic       wake_uf;
  logic       comp_end;
  logic       card_hit;

  function automatic logic [15:0] join_bytes(input logic [7:0] hi,
                                             input logic [7:0] lo);
    join_bytes = {hi, lo};
  endfunction

  // readback mux; unmapped indices read as zero
  function automatic logic [7:0] read_reg(
      input wutcd_pkg::wutcd_state_t st,
      input logic [7:0]              idx);
    if (idx == `WUTCD_IDX_COMP_RELOAD_HI) begin
      read_reg = st.comp_reload_hi;
    end else if (idx == `WUTCD_IDX_COMP_RELOAD_LO) begin
      read_reg = st.comp_reload_lo;
    end else if (idx == `WUTCD_IDX_COMP_COUNT_HI) begin
      read_reg = st.comp_count[15:8];
    end else if (idx == `WUTCD_IDX_COMP_COUNT_LO) begin
      read_reg = st.comp_count[7:0];
    end else if (idx == `WUTCD_IDX_WAKE_CTRL) begin
      // running shown, gate bit reads zero
      read_reg = {st.active, 1'b0, st.trim, st.card_detect,
                  st.reload, st.auto_wake, st.clk_sel};
    end else if (idx == `WUTCD_IDX_WAKE_RELOAD_HI) begin
      read_reg = st.wake_reload_hi;
    end else if (idx == `WUTCD_IDX_WAKE_RELOAD_LO) begin
      read_reg = st.wake_reload_lo;
    end else if (idx == `WUTCD_IDX_WAKE_COUNT_HI) begin
      read_reg = st.wake_count[15:8];
    end else if (idx == `WUTCD_IDX_WAKE_COUNT_LO) begin
      read_reg = st.wake_count[7:0];
    end else if (idx == `WUTCD_IDX_STATUS) begin
      read_reg = {4'h0, st.card_seen,
                  st.det != wutcd_pkg::WUTCD_DET_IDLE,
                  st.card_flag, st.irq_flag};
    end else begin
      read_reg = 8'h00;
    end
  endfunction

  // bus decode: one request per ack, low byte lane carries data
  assign wb_req    = wb_cyc_in & wb_stb_in & ~s_ff.ack;
  assign wb_adr_ok = (wb_adr_in[11:10] == 2'b00) &&
                     (wb_adr_in[1:0] == 2'b00);
  assign wb_idx    = wb_adr_in[9:2];
  assign wb_wr     = wb_req & wb_we_in & wb_sel_in[0] & wb_adr_ok;
  assign ctrl_wr   = wb_wr && (wb_idx == `WUTCD_IDX_WAKE_CTRL);

  // a write changes running only with gate bit set; a one-shot underflow also clears it
  assign wake_start = ctrl_wr && wb_dat_in[`WUTCD_CTRL_GATE] &&
                      wb_dat_in[`WUTCD_CTRL_ACTIVE] && !s_ff.active;
  assign wake_stop  = ctrl_wr && wb_dat_in[`WUTCD_CTRL_GATE] &&
                      !wb_dat_in[`WUTCD_CTRL_ACTIVE];

  // underflow on the tick that reaches zero
  assign wake_uf = s_ff.active && presc_tick && !wake_start &&
                   !wake_stop && (s_ff.wake_count <= 16'h0001);

  // window closes when companion count reaches zero
  assign comp_end = (s_ff.det == wutcd_pkg::WUTCD_DET_FIELD) &&
                    comp_tick_in && (s_ff.comp_count <= 16'h0001);
  assign card_hit = s_ff.card_seen | card_present_in;

  wutcd_prescale u_prescale (
    .clk_sys_in  (clk_sys_in),
    .rst_b_in    (rst_b_in),
    .clear_in    (wake_start),
    .sel_in      (s_ff.clk_sel),
    .lfo_tick_in (lfo_tick_in),
    .tick_out    (presc_tick)
  );

  always_comb begin
    nxt_s = s_ff;
    nxt_s.ack = 1'b0;
    nxt_s.wake_up = 1'b0;
    nxt_s.trim_start = 1'b0;
    nxt_s.power_down = 1'b0;
    nxt_s.detect_start = 1'b0;

    // bus answer one cycle after the request
    if (wb_req) begin
      nxt_s.ack = 1'b1;
      if (wb_adr_ok && !wb_we_in) begin
        nxt_s.rdata = {24'h000000, read_reg(s_ff, wb_idx)};
      end else begin
        nxt_s.rdata = 32'h00000000;
      end
    end

    // register writes; flag clears come before hardware sets
    if (wb_wr) begin
      if (wb_idx == `WUTCD_IDX_COMP_RELOAD_HI) begin
        nxt_s.comp_reload_hi = wb_dat_in[7:0];
      end else if (wb_idx == `WUTCD_IDX_COMP_RELOAD_LO) begin
        nxt_s.comp_reload_lo = wb_dat_in[7:0];
      end else if (wb_idx == `WUTCD_IDX_WAKE_CTRL) begin
        nxt_s.trim        = wb_dat_in[`WUTCD_CTRL_TRIM];
        nxt_s.card_detect = wb_dat_in[`WUTCD_CTRL_CARD_DETECT];
        nxt_s.reload      = wb_dat_in[`WUTCD_CTRL_RELOAD];
        nxt_s.auto_wake   = wb_dat_in[`WUTCD_CTRL_AUTO_WAKE];
        nxt_s.clk_sel     = wb_dat_in[`WUTCD_CTRL_CLKSEL_HI:
                                      `WUTCD_CTRL_CLKSEL_LO];
        if (wb_dat_in[`WUTCD_CTRL_GATE]) begin
          nxt_s.active = wb_dat_in[`WUTCD_CTRL_ACTIVE];
        end
      end else if (wb_idx == `WUTCD_IDX_WAKE_RELOAD_HI) begin
        nxt_s.wake_reload_hi = wb_dat_in[7:0];
      end else if (wb_idx == `WUTCD_IDX_WAKE_RELOAD_LO) begin
        nxt_s.wake_reload_lo = wb_dat_in[7:0];
      end else if (wb_idx == `WUTCD_IDX_STATUS) begin
        if (wb_dat_in[`WUTCD_STAT_IRQ_FLAG]) begin
          nxt_s.irq_flag = 1'b0;
        end
        if (wb_dat_in[`WUTCD_STAT_CARD_FLAG]) begin
          nxt_s.card_flag = 1'b0;
        end
      end
    end

    // start loads wake count from reload bytes
    if (wake_start) begin
      nxt_s.wake_count = join_bytes(s_ff.wake_reload_hi,
                                    s_ff.wake_reload_lo);
    end else if (wake_uf) begin
      // underflow sets flag, wins over clear
      nxt_s.irq_flag = 1'b1;
      nxt_s.wake_up = s_ff.auto_wake;
      nxt_s.trim_start = s_ff.trim;
      // detection mode reloads with no gap
      if (s_ff.reload || s_ff.card_detect) begin
        nxt_s.wake_count = join_bytes(s_ff.wake_reload_hi,
                                      s_ff.wake_reload_lo);
      end else begin
        nxt_s.wake_count = 16'h0000;
        nxt_s.active = 1'b0;
      end
    end else if (s_ff.active && presc_tick && !wake_stop) begin
      nxt_s.wake_count = s_ff.wake_count - 16'h0001;
    end

    // trimming finished: back to sleep only when auto wake is set
    if (trim_done_in && s_ff.auto_wake) begin
      nxt_s.power_down = 1'b1;
      nxt_s.stay_active = 1'b0;
    end

    // card detection sequence
    case (s_ff.det)
      wutcd_pkg::WUTCD_DET_IDLE: begin
        if (wake_uf && s_ff.card_detect) begin
          // companion loads from both reload bytes
          nxt_s.comp_count = join_bytes(s_ff.comp_reload_hi,
                                        s_ff.comp_reload_lo);
          nxt_s.card_seen = 1'b0;
          nxt_s.rf_field = 1'b1;
          nxt_s.detect_start = 1'b1;
          nxt_s.stay_active = 1'b0;
          nxt_s.det = wutcd_pkg::WUTCD_DET_FIELD;
        end
      end
      wutcd_pkg::WUTCD_DET_FIELD: begin
        // field held on while companion counts
        nxt_s.card_seen = card_hit;
        if (comp_end) begin
          nxt_s.comp_count = 16'h0000;
          nxt_s.rf_field = 1'b0;
          nxt_s.det = wutcd_pkg::WUTCD_DET_DONE;
        end else if (comp_tick_in) begin
          nxt_s.comp_count = s_ff.comp_count - 16'h0001;
        end
      end
      wutcd_pkg::WUTCD_DET_DONE: begin
        nxt_s.det = wutcd_pkg::WUTCD_DET_IDLE;
        if (s_ff.card_seen) begin
          // card found: flag and stay awake
          nxt_s.card_flag = 1'b1;
          nxt_s.stay_active = 1'b1;
        end else if (s_ff.auto_wake) begin
          // no card: power down when enabled
          nxt_s.power_down = 1'b1;
        end
      end
      default: begin
        nxt_s.det = wutcd_pkg::WUTCD_DET_IDLE;
        nxt_s.rf_field = 1'b0;
      end
    endcase

    // interrupt line follows the sticky flags in the same cycle
    nxt_s.irq = nxt_s.irq_flag | nxt_s.card_flag;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      s_ff <= '0;
      s_ff.det <= wutcd_pkg::WUTCD_DET_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign wb_dat_out       = s_ff.rdata;
  assign wb_ack_out       = s_ff.ack;
  assign irq_out          = s_ff.irq;
  assign wake_up_out      = s_ff.wake_up;
  assign trim_start_out   = s_ff.trim_start;
  assign power_down_out   = s_ff.power_down;
  assign stay_active_out  = s_ff.stay_active;
  assign detect_start_out = s_ff.detect_start;
  assign rf_field_out     = s_ff.rf_field;

endmodule
`default_nettype wire

// File: verification/wutcd_chk.sv
// bus handshake and event output checks for the wake-up timer block
`timescale 1ns/1ns
`default_nettype none

module wutcd_chk (
  // clock and reset
  input wire logic        clk_sys_in,
  input wire logic        rst_b_in,
  // bus
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  // events
  input wire logic        irq_out,
  input wire logic        wake_up_out,
  input wire logic        trim_start_out,
  input wire logic        power_down_out,
  input wire logic        stay_active_out,
  input wire logic        detect_start_out,
  input wire logic        rf_field_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_taken;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence

  sequence s_ack_pulse;
    wb_ack_out ##1 !wb_ack_out;
  endsequence

  a_ack_handshake: assert property (s_taken |=> s_ack_pulse)
    else $error("ack not a single pulse after request");
  a_ack_has_req: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  a_read_high_zero: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_write_reads_zero: assert property (
    wb_ack_out && $past(wb_we_in) |-> wb_dat_out == 32'h0)
    else $error("read data not zero on write");
  a_field_at_start: assert property (detect_start_out |-> rf_field_out)
    else $error("detection started without field");
  a_no_retrigger: assert property (
    $past(rf_field_out) && rf_field_out |-> !detect_start_out)
    else $error("detection restarted inside window");
  a_underflow_irq: assert property (
    wake_up_out || trim_start_out |-> ##[0:2] irq_out)
    else $error("underflow without interrupt");
  a_nocard_power: assert property (power_down_out |-> !stay_active_out)
    else $error("power down while card found");
  a_wake_single: assert property (wake_up_out |=> !wake_up_out)
    else $error("wake pulse longer than one cycle");
endmodule

bind wutcd_top wutcd_chk wutcd_chk_i (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .irq_out(irq_out), .wake_up_out(wake_up_out),
  .trim_start_out(trim_start_out), .power_down_out(power_down_out),
  .stay_active_out(stay_active_out), .detect_start_out(detect_start_out),
  .rf_field_out(rf_field_out)
);
`default_nettype wire

// File: verification/wutcd_top_test.sv
// self-checking bench for the wake-up timer block
`timescale 1ns/1ns
`default_nettype none

module wutcd_top_test;
  logic        clk_sys_in;
  logic        rst_b_in;
  logic        wb_cyc_in;
  logic        wb_stb_in;
  logic        wb_we_in;
  logic [11:0] wb_adr_in;
  logic [3:0]  wb_sel_in;
  logic [31:0] wb_dat_in;
  logic [31:0] wb_dat_out;
  logic        wb_ack_out;
  logic        lfo_tick_in;
  logic        comp_tick_in;
  logic        card_present_in;
  logic        trim_done_in;
  logic        irq_out;
  logic        wake_up_out;
  logic        trim_start_out;
  logic        power_down_out;
  logic        stay_active_out;
  logic        detect_start_out;
  logic        rf_field_out;
  logic        lfo_en;
  logic        comp_en;
  logic [2:0]  gen_div;
  logic [7:0]  junk;
  int          tick_cnt;
  int          t0;
  int          fail_count;
  int          total_checks;
  int          div_tab [4] = '{1, 8, 16, 32};

  wutcd_top wutcd_top_i (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .lfo_tick_in(lfo_tick_in),
    .comp_tick_in(comp_tick_in), .card_present_in(card_present_in),
    .trim_done_in(trim_done_in), .irq_out(irq_out),
    .wake_up_out(wake_up_out), .trim_start_out(trim_start_out),
    .power_down_out(power_down_out), .stay_active_out(stay_active_out),
    .detect_start_out(detect_start_out), .rf_field_out(rf_field_out)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  // ticks 8 cycles apart so a pulse is seen before the next tick counts
  always @(posedge clk_sys_in) begin
    gen_div <= gen_div + 3'h1;
    lfo_tick_in <= lfo_en && gen_div == 3'h7;
    comp_tick_in <= comp_en && gen_div == 3'h3;
    if (lfo_en && gen_div == 3'h7) begin
      tick_cnt <= tick_cnt + 1;
    end
  end

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wb_cycle(input logic we, input logic [7:0] idx,
                          input logic [7:0] wd, output logic [7:0] rd);
    int n;
    @(posedge clk_sys_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_sel_in <= 4'h1;
    wb_adr_in <= {2'h0, idx, 2'h0};
    wb_dat_in <= {24'h0, wd};
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 16);
    rd = wb_dat_out[7:0];
    check("bus ack", {15'h0, wb_ack_out}, 16'h1);
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb_cycle(1'b1, idx, d, junk);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] idx,
                        input logic [7:0] exp);
    logic [7:0] v;
    wb_cycle(1'b0, idx, 8'h00, v);
    check(name, {8'h0, v}, {8'h0, exp});
  endtask

  // ticks held off around the start so none lands on the load edge
  task automatic start_timer(input logic [7:0] ctrl);
    lfo_en <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    wr(8'h23, ctrl);
    t0 = tick_cnt;
    lfo_en <= 1'b1;
  endtask

  task automatic wait_evt(input logic [4:0] m);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while ((m & {stay_active_out, detect_start_out, power_down_out,
                     trim_start_out, wake_up_out}) == 5'h0 && n < 4000);
    check("event", {15'h0, n < 4000}, 16'h1);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_sys_in);
    fail_count++;
    $display("[FAIL] watchdog expected done seen hang");
    close_out();
  end

  initial begin
    rst_b_in = 1'b0;
    wb_cyc_in = 1'b0;
    wb_stb_in = 1'b0;
    wb_we_in = 1'b0;
    wb_adr_in = 12'h000;
    wb_sel_in = 4'h0;
    wb_dat_in = 32'h0;
    lfo_tick_in = 1'b0;
    comp_tick_in = 1'b0;
    card_present_in = 1'b0;
    trim_done_in = 1'b0;
    lfo_en = 1'b0;
    comp_en = 1'b0;
    gen_div = 3'h0;
    tick_cnt = 0;
    fail_count = 0;
    total_checks = 0;
    repeat (6) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    rd_chk("ctrl reset", 8'h23, 8'h00);
    wr(8'h20, 8'ha5);
    rd_chk("comp reload lo", 8'h20, 8'ha5);
    wr(8'h21, 8'hff);
    rd_chk("comp count hi", 8'h21, 8'h00);
    rd_chk("unmapped", 8'h10, 8'h00);
    wr(8'h23, 8'h80);
    rd_chk("ctrl no gate", 8'h23, 8'h00);
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      wr(8'h25, 8'h02);
      start_timer(8'hc4 | 8'(s));
      wait_evt(5'h01);
      check("lfo ticks", 16'(tick_cnt - t0), 16'(2 * div_tab[s]));
      rd_chk("ctrl stopped", 8'h23, 8'h04 | 8'(s));
      rd_chk("irq flag", 8'h30, 8'h01);
      wr(8'h30, 8'h01);
    end
    $display("test clock select done");
    wr(8'h25, 8'h03);
    // trim timer assumed prepared; detection is off here
    start_timer(8'hec);
    wait_evt(5'h02);
    check("trim period 1", 16'(tick_cnt - t0), 16'h3);
    wait_evt(5'h02);
    check("trim period 2", 16'(tick_cnt - t0), 16'h6);
    wr(8'h23, 8'h2c);
    rd_chk("ctrl running", 8'h23, 8'hac);
    wr(8'h23, 8'h6c);
    rd_chk("ctrl stop", 8'h23, 8'h2c);
    wr(8'h30, 8'h01);
    rd_chk("irq cleared", 8'h30, 8'h00);
    check("irq pin", {15'h0, irq_out}, 16'h0);
    // auto wake set: finished trim returns to sleep
    @(posedge clk_sys_in);
    trim_done_in <= 1'b1;
    @(posedge clk_sys_in);
    trim_done_in <= 1'b0;
    @(posedge clk_sys_in);
    check("trim power down", {15'h0, power_down_out}, 16'h1);
    $display("test auto reload done");
    wr(8'h1f, 8'h00);
    wr(8'h20, 8'h04);
    wr(8'h25, 8'h02);
    // auto wake set so a missed card means sleep
    start_timer(8'hdc);
    wait_evt(5'h08);
    check("field on", {15'h0, rf_field_out}, 16'h1);
    // no reception runs, so count reads are allowed
    rd_chk("comp count hi", 8'h21, 8'h00);
    rd_chk("comp count lo", 8'h22, 8'h04);
    wr(8'h20, 8'h07);
    rd_chk("count kept", 8'h22, 8'h04);
    comp_en <= 1'b1;
    wait_evt(5'h04);
    check("stay active", {15'h0, stay_active_out}, 16'h0);
    comp_en <= 1'b0;
    wait_evt(5'h08);
    rd_chk("new comp load", 8'h22, 8'h07);
    card_present_in <= 1'b1;
    comp_en <= 1'b1;
    wait_evt(5'h10);
    check("card irq", {15'h0, irq_out}, 16'h1);
    wr(8'h23, 8'h40);
    wr(8'h30, 8'h01);
    wb_cycle(1'b0, 8'h30, 8'h00, junk);
    check("card flag", {8'h0, junk & 8'h03}, 16'h0002);
    $display("test detection done");
    close_out();
  end
endmodule
`default_nettype wire
